// [irqc_pkg.sv]
// =====================================================================
// Shared constants of the interrupt controller
package irqc_pkg;
   // =================================================================
   // Sizes
   localparam int NODES     = 8;  // interrupt nodes
   localparam int CHANS     = 8;  // event transfer channels
   localparam int FAST_IN   = 2;  // fast external inputs, nodes 0..1
   localparam int PERIPH_IN = 4;  // peripheral requests, nodes 2..5
   localparam int PERIPH_LO = 2;  // first node fed by a peripheral
   localparam int LVL_W     = 4;  // sixteen priority levels
   localparam int PTR_W     = 24;
   localparam int CNT_W     = 8;
   localparam int VEC_W     = 16;
   localparam int TRAP_W    = 8;

   // =================================================================
   // Trap numbers and vectors
   localparam logic [TRAP_W-1:0] TRAP_BASE  = 8'h10; // node 0 trap
   localparam int                VEC_SHIFT  = 2;     // vector = trap*4

   // =================================================================
   // APB map (byte addresses)
   localparam logic [11:0] NODE_BASE = 12'h000; // 0x000 + 4*node
   localparam logic [11:0] CHAN_BASE = 12'h100; // 0x100 + 16*chan
   localparam logic [1:0]  CH_SRC    = 2'h0;    // +0x0 source pointer
   localparam logic [1:0]  CH_DST    = 2'h1;    // +0x4 dest pointer
   localparam logic [1:0]  CH_CFG    = 2'h2;    // +0x8 count and mode
   localparam logic [11:0] EDGE_ADDR = 12'h200;
   localparam logic [11:0] STAT_ADDR = 12'h204;
   localparam logic [11:0] MASK_ADDR = 12'h208;
   localparam logic [11:0] CUR_ADDR  = 12'h20C;

   // =================================================================
   // Node control fields
   localparam int NC_LVL_LSB = 0;  // [3:0] priority level
   localparam int NC_XFER    = 4;  // serviced by transfer channel
   localparam int NC_ENA     = 6;  // enable flag
   localparam int NC_REQ     = 7;  // request flag

   // Channel configuration fields
   localparam int CF_CNT_LSB = 0;  // [7:0] transfer counter
   localparam int CF_CONT    = 8;  // continuous mode
   localparam int CF_WORD    = 9;  // word (else byte)
   localparam int CF_INCS    = 10; // increment source
   localparam int CF_INCD    = 11; // increment destination

   // Edge select codes, two bits per fast input
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic [PTR_W-1:0] STEP_BYTE = 24'h000001;
   localparam logic [PTR_W-1:0] STEP_WORD = 24'h000002;

   // =================================================================
   // Service sequencer
   typedef enum logic [1:0] {
      IRQC_IDLE = 2'b00,
      IRQC_VEC  = 2'b01,
      IRQC_XFER = 2'b10
   } irqc_state_t;
endpackage : irqc_pkg

// [irqc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module irqc_top (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         nrst,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Request sources
   input  wire logic [irqc_pkg::FAST_IN-1:0]   fast_in,
   input  wire logic [irqc_pkg::PERIPH_IN-1:0] periph_req,
   // CPU core
   input  wire logic [irqc_pkg::LVL_W-1:0]   cpu_ilvl,
   input  wire logic                         trap_req,
   input  wire logic [irqc_pkg::TRAP_W-1:0]  trap_num,
   output logic                              cpu_int_req,
   output logic [irqc_pkg::VEC_W-1:0]        cpu_int_vec,
   output logic [irqc_pkg::LVL_W-1:0]        cpu_int_lvl,
   input  wire logic                         cpu_int_ack,
   // Stolen-cycle transfer port
   output logic                              mem_req,
   output logic [irqc_pkg::PTR_W-1:0]        mem_src,
   output logic [irqc_pkg::PTR_W-1:0]        mem_dst,
   output logic                              mem_word,
   input  wire logic                         mem_gnt,
   // Interrupt to system
   output logic                              irq
);
   localparam int N  = irqc_pkg::NODES;
   localparam int C  = irqc_pkg::CHANS;
   localparam int LW = irqc_pkg::LVL_W;
   localparam int PW = irqc_pkg::PTR_W;
   localparam int CW = irqc_pkg::CNT_W;

   // ==================================================================
   // Helpers
   // Vector of a trap number: trap times four
   function automatic logic [irqc_pkg::VEC_W-1:0] vec_of(
      input logic [irqc_pkg::TRAP_W-1:0] t);
      // Zero-extend first so the shift cannot lose trap bits
      vec_of = {{(irqc_pkg::VEC_W - irqc_pkg::TRAP_W){1'b0}}, t}
               << irqc_pkg::VEC_SHIFT;
   endfunction : vec_of

   // Pointer step for one transfer
   function automatic logic [PW-1:0] step_of(input logic word);
      step_of = word ? irqc_pkg::STEP_WORD : irqc_pkg::STEP_BYTE;
   endfunction : step_of

   // ==================================================================
   // State
   logic [LW-1:0]       lvl  [N];
   logic [N-1:0]        ena;
   logic [N-1:0]        xfer;
   logic [N-1:0]        req;
   logic [PW-1:0]       src  [C];
   logic [PW-1:0]       dst  [C];
   logic [CW-1:0]       cnt  [C];
   logic [C-1:0]        cont;
   logic [C-1:0]        word;
   logic [C-1:0]        incs;
   logic [C-1:0]        incd;
   logic [2*irqc_pkg::FAST_IN-1:0] edge_sel;
   logic [irqc_pkg::FAST_IN-1:0]   fast_prev;
   logic [C-1:0]        stat;
   logic [C-1:0]        mask;
   logic                trap_pend;
   logic [irqc_pkg::TRAP_W-1:0] trap_hold;
   logic [2:0]          svc_node;
   irqc_pkg::irqc_state_t state;
   irqc_pkg::irqc_state_t next_state;

   // ==================================================================
   // APB decode
   wire         wr_acc   = psel & penable & pwrite;
   wire         rd_setup = psel & ~penable & ~pwrite;
   wire         rd_acc   = psel & penable & ~pwrite;
   wire         node_hit = (paddr[11:5] == irqc_pkg::NODE_BASE[11:5])
                           & (paddr[1:0] == 2'h0);
   wire         chan_hit = (paddr[11:7] == irqc_pkg::CHAN_BASE[11:7])
                           & (paddr[3:2] != 2'h3) & (paddr[1:0] == 2'h0);
   wire [2:0]   node_ix  = paddr[4:2];
   wire [2:0]   chan_ix  = paddr[6:4];
   wire         edge_hit = paddr == irqc_pkg::EDGE_ADDR;
   wire         stat_hit = paddr == irqc_pkg::STAT_ADDR;
   wire         mask_hit = paddr == irqc_pkg::MASK_ADDR;
   wire         cur_hit  = paddr == irqc_pkg::CUR_ADDR;
   wire         mapped   = node_hit | chan_hit | edge_hit | stat_hit
                           | mask_hit | cur_hit;

   // Zero wait states keep the bus simple; read data is captured in
   // the setup cycle so it comes straight from a flip-flop
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ==================================================================
   // Read mux
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      if (node_hit) begin
         rd_val[irqc_pkg::NC_LVL_LSB +: LW] = lvl[node_ix];
         rd_val[irqc_pkg::NC_XFER]          = xfer[node_ix];
         rd_val[irqc_pkg::NC_ENA]           = ena[node_ix];
         rd_val[irqc_pkg::NC_REQ]           = req[node_ix];
      end else if (chan_hit) begin
         case (paddr[3:2])
            irqc_pkg::CH_SRC: rd_val[PW-1:0] = src[chan_ix];
            irqc_pkg::CH_DST: rd_val[PW-1:0] = dst[chan_ix];
            default: begin
               rd_val[irqc_pkg::CF_CNT_LSB +: CW] = cnt[chan_ix];
               rd_val[irqc_pkg::CF_CONT] = cont[chan_ix];
               rd_val[irqc_pkg::CF_WORD] = word[chan_ix];
               rd_val[irqc_pkg::CF_INCS] = incs[chan_ix];
               rd_val[irqc_pkg::CF_INCD] = incd[chan_ix];
            end
         endcase
      end else if (edge_hit) begin
         rd_val[2*irqc_pkg::FAST_IN-1:0] = edge_sel;
      end else if (stat_hit) begin
         rd_val[C-1:0] = stat;
      end else if (mask_hit) begin
         rd_val[C-1:0] = mask;
      end else if (cur_hit) begin
         rd_val[1:0] = state;       // sequencer state
         rd_val[2]   = trap_pend;
         rd_val[6:4] = svc_node;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) prdata <= 32'h0000_0000;
      else if (rd_setup) prdata <= rd_val;
   end

   // ==================================================================
   // Hardware request events
   logic [N-1:0] hw_set;
   always_comb begin
      hw_set = '0;
      for (int i = 0; i < irqc_pkg::FAST_IN; i++) begin
         // Either edge may be armed independently
         case (edge_sel[2*i +: 2])
            irqc_pkg::EDGE_RISE: hw_set[i] = fast_in[i] & ~fast_prev[i];
            irqc_pkg::EDGE_FALL: hw_set[i] = ~fast_in[i] & fast_prev[i];
            irqc_pkg::EDGE_BOTH: hw_set[i] = fast_in[i] ^ fast_prev[i];
            default:             hw_set[i] = 1'b0;
         endcase
      end
      for (int i = 0; i < irqc_pkg::PERIPH_IN; i++)
         hw_set[irqc_pkg::PERIPH_LO + i] = periph_req[i];
      // Nodes 6 and 7 have no source: only software sets them
   end

   // ==================================================================
   // Arbitration: highest enabled level above the running one
   logic          win_any;
   logic [2:0]    win_ix;
   logic [LW-1:0] win_lvl;
   always_comb begin
      win_any = 1'b0;
      win_ix  = 3'h0;
      win_lvl = cpu_ilvl;
      for (int i = 0; i < N; i++) begin
         // Strict compare keeps the lower index on a tie
         if (req[i] & ena[i] & (lvl[i] > win_lvl)) begin
            win_any = 1'b1;
            win_ix  = 3'(i);
            win_lvl = lvl[i];
         end
      end
   end

   // A node in channel mode with a spent counter goes to its vector, unless its channel is continuous
   wire win_xfer = xfer[win_ix]
                   & ((cnt[win_ix] != '0) | cont[win_ix]);

   // ==================================================================
   // Service sequencer
   always_comb begin
      next_state = state;
      case (state)
         irqc_pkg::IRQC_IDLE: begin
            if (trap_pend)     next_state = irqc_pkg::IRQC_VEC;
            else if (win_any && win_xfer)
               next_state = irqc_pkg::IRQC_XFER;
            else if (win_any)  next_state = irqc_pkg::IRQC_VEC;
         end
         irqc_pkg::IRQC_VEC:
            if (cpu_int_ack) next_state = irqc_pkg::IRQC_IDLE;
         irqc_pkg::IRQC_XFER:
            if (mem_gnt)     next_state = irqc_pkg::IRQC_IDLE;
         default:            next_state = irqc_pkg::IRQC_IDLE;
      endcase
   end

   // Service starts on the edge after the request is seen, so the
   // controller adds one cycle; the rest of the entry time is the
   // CPU's, and slow instruction fetches stretch it further
   wire start     = (state == irqc_pkg::IRQC_IDLE)
                    & (next_state != irqc_pkg::IRQC_IDLE);
   wire trap_go   = start & trap_pend;
   wire vec_done  = (state == irqc_pkg::IRQC_VEC) & cpu_int_ack;
   wire xfer_done = (state == irqc_pkg::IRQC_XFER) & mem_gnt;
   wire [CW-1:0] cnt_now = cnt[svc_node];
   // Transfer that drains the counter leaves the request standing
   wire          last_xfer = xfer_done & ~cont[svc_node]
                             & (cnt_now == CW'(1));
   logic         svc_trap; // current VEC service came from a trap

   assign cpu_int_req = state == irqc_pkg::IRQC_VEC;
   assign mem_req     = state == irqc_pkg::IRQC_XFER;
   assign irq         = |(stat & mask);

   // Sequencer and service latch
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state       <= irqc_pkg::IRQC_IDLE;
         svc_node    <= 3'h0;
         svc_trap    <= 1'b0;
         cpu_int_vec <= '0;
         cpu_int_lvl <= '0;
         mem_src     <= '0;
         mem_dst     <= '0;
         mem_word    <= 1'b0;
      end else begin
         state <= next_state;
         if (start) begin
            svc_node    <= win_ix;
            svc_trap    <= trap_pend;
            cpu_int_vec <= trap_pend ? vec_of(trap_hold)
                           : vec_of(irqc_pkg::TRAP_BASE
                                    + 8'(win_ix));
            cpu_int_lvl <= trap_pend ? cpu_ilvl : win_lvl;
            mem_src     <= src[win_ix];
            mem_dst     <= dst[win_ix];
            mem_word    <= word[win_ix];
         end
      end
   end

   // Trap capture; a new trap while one waits is dropped unless the waiting one starts service in that cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trap_pend <= 1'b0;
         trap_hold <= '0;
      end else if (trap_req && (!trap_pend || trap_go)) begin
         trap_pend <= 1'b1;
         trap_hold <= trap_num;
      end else if (trap_go) begin
         trap_pend <= 1'b0;
      end
   end

   // Fast input history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) fast_prev <= '0;
      else       fast_prev <= fast_in;
   end

   // ==================================================================
   // Node control registers
   // Hardware set beats both a software clear and a service clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < N; i++) lvl[i] <= '0;
         ena  <= '0;
         xfer <= '0;
         req  <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_acc && node_hit && node_ix == 3'(i)) begin
               lvl[i]  <= pwdata[irqc_pkg::NC_LVL_LSB +: LW];
               xfer[i] <= pwdata[irqc_pkg::NC_XFER];
               ena[i]  <= pwdata[irqc_pkg::NC_ENA];
               req[i]  <= pwdata[irqc_pkg::NC_REQ] | hw_set[i];
            end else if (hw_set[i]) begin
               req[i]  <= 1'b1;
            end else if (svc_node == 3'(i) && !svc_trap
                         && (vec_done || (xfer_done && !last_xfer))) begin
               req[i]  <= 1'b0;
            end
         end
      end
   end

   // ==================================================================
   // Channel registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < C; i++) begin
            src[i] <= '0;
            dst[i] <= '0;
            cnt[i] <= '0;
         end
         cont <= '0;
         word <= '0;
         incs <= '0;
         incd <= '0;
      end else begin
         for (int i = 0; i < C; i++) begin
            if (xfer_done && svc_node == 3'(i)) begin
               if (incs[i]) src[i] <= src[i] + step_of(word[i]);
               if (incd[i]) dst[i] <= dst[i] + step_of(word[i]);
               if (!cont[i]) cnt[i] <= cnt[i] - CW'(1);
            end else if (wr_acc && chan_hit && chan_ix == 3'(i)) begin
               case (paddr[3:2])
                  irqc_pkg::CH_SRC: src[i] <= pwdata[PW-1:0];
                  irqc_pkg::CH_DST: dst[i] <= pwdata[PW-1:0];
                  default: begin
                     cnt[i]  <= pwdata[irqc_pkg::CF_CNT_LSB +: CW];
                     cont[i] <= pwdata[irqc_pkg::CF_CONT];
                     word[i] <= pwdata[irqc_pkg::CF_WORD];
                     incs[i] <= pwdata[irqc_pkg::CF_INCS];
                     incd[i] <= pwdata[irqc_pkg::CF_INCD];
                  end
               endcase
            end
         end
      end
   end

   // ==================================================================
   // Edge select, mask and sticky status
   // A drain event in the clearing read's cycle stays set
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         edge_sel <= '0;
         mask     <= '0;
         stat     <= '0;
      end else begin
         if (wr_acc && edge_hit)
            edge_sel <= pwdata[2*irqc_pkg::FAST_IN-1:0];
         if (wr_acc && mask_hit) mask <= pwdata[C-1:0];
         for (int i = 0; i < C; i++) begin
            if (last_xfer && svc_node == 3'(i)) stat[i] <= 1'b1;
            else if (rd_acc && stat_hit)        stat[i] <= 1'b0;
         end
      end
   end
endmodule : irqc_top
`default_nettype wire

// [irqc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Port checker for the interrupt controller
module irqc_assertions (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         nrst,
   // APB
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic [11:0]                  paddr,
   input wire logic                         pready,
   input wire logic                         pslverr,
   // CPU side
   input wire logic                         trap_req,
   input wire logic [irqc_pkg::LVL_W-1:0]   cpu_ilvl,
   input wire logic                         cpu_int_req,
   input wire logic [irqc_pkg::VEC_W-1:0]   cpu_int_vec,
   input wire logic [irqc_pkg::LVL_W-1:0]   cpu_int_lvl,
   input wire logic                         cpu_int_ack,
   input wire logic                         mem_req,
   input wire logic [irqc_pkg::PTR_W-1:0]   mem_src,
   input wire logic [irqc_pkg::PTR_W-1:0]   mem_dst,
   input wire logic                         mem_gnt,
   input wire logic                         irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // =================================================================
   // Bus answers
   chk_ready_const: assert property (pready)
      else $error("pready dropped");
   chk_err_unmapped: assert property (psel && penable
      && paddr[11:7] == 5'h02 && paddr[3:2] == 2'h3 |-> pslverr)
      else $error("unmapped channel slot not refused");

   // =================================================================
   // Vectored service: aligned vector, held until taken
   chk_vec_fixed: assert property (cpu_int_req |->
      cpu_int_vec[1:0] == 2'h0 && cpu_int_vec[15:10] == 6'h00)
      else $error("vector not trap times four");
   chk_vec_hold: assert property (cpu_int_req && !cpu_int_ack |=>
      cpu_int_req && $stable(cpu_int_vec) && $stable(cpu_int_lvl))
      else $error("vector changed while waiting");
   chk_ack_ends: assert property (cpu_int_req && cpu_int_ack |=>
      !cpu_int_req)
      else $error("request stayed after acknowledge");
   chk_level_above: assert property ($rose(cpu_int_req) |->
      cpu_int_lvl >= cpu_ilvl)
      else $error("service below running level");
   chk_trap_entry: assert property (trap_req && !cpu_int_req
      && !mem_req |-> ##[1:4] cpu_int_req)
      else $error("trap not entered");

   // =================================================================
   // Stolen cycle: no vector, one grant ends it
   chk_steal_novec: assert property (mem_req |-> !cpu_int_req)
      else $error("vector during transfer");
   chk_gnt_ends: assert property (mem_req && mem_gnt |=>
      !mem_req && !cpu_int_req)
      else $error("transfer took more than one cycle");
   chk_xfer_hold: assert property (mem_req && !mem_gnt |=>
      mem_req && $stable(mem_src) && $stable(mem_dst))
      else $error("transfer address moved while waiting");

   // Main scenarios seen
   cov_vector: cover property (cpu_int_req && cpu_int_ack);
   cov_xfer: cover property (mem_req && mem_gnt);
   cov_irq: cover property ($rose(irq));
endmodule : irqc_assertions

bind irqc_top irqc_assertions irqc_assertions_i (.clk, .nrst, .psel,
   .penable, .paddr, .pready, .pslverr, .trap_req, .cpu_ilvl,
   .cpu_int_req, .cpu_int_vec, .cpu_int_lvl, .cpu_int_ack, .mem_req,
   .mem_src, .mem_dst, .mem_gnt, .irq);
`default_nettype wire

// [irqc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// CPU core model: takes vectors and grants stolen cycles
module irqc_cpu_model (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Answer delay in cycles, zero answers at once
   input wire logic [3:0] dly,
   // Controller side
   input wire logic       cpu_int_req,
   input wire logic       mem_req,
   output logic           cpu_int_ack,
   output logic           mem_gnt
);
   logic [3:0] wait_cnt;

   // One answer per request, held until the controller samples it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpu_int_ack <= 1'b0;
         mem_gnt     <= 1'b0;
         wait_cnt    <= 4'h0;
      end else if ((cpu_int_req || mem_req) && !cpu_int_ack && !mem_gnt) begin
         if (wait_cnt >= dly) begin
            cpu_int_ack <= cpu_int_req;
            mem_gnt     <= mem_req;
            wait_cnt    <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         cpu_int_ack <= 1'b0; // Pulse ends after the sampling edge
         mem_gnt     <= 1'b0;
      end
   end
endmodule : irqc_cpu_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Self-checking bench for the interrupt controller
module testbench;
   logic clk = 1'b0;
   logic nrst, psel, penable, pwrite, pready, pslverr, trap_req, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  fast_in;
   logic [3:0]  periph_req, cpu_ilvl, cpu_int_lvl, dly;
   logic [7:0]  trap_num;
   logic        cpu_int_req, cpu_int_ack, mem_req, mem_word, mem_gnt, lw;
   logic [15:0] cpu_int_vec, lvec;
   logic [23:0] mem_src, mem_dst, lsrc, ldst;
   int num_errors = 0, n_compared = 0, nv = 0, nx = 0, i;

   irqc_top irqc_top_i (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .fast_in, .periph_req,
      .cpu_ilvl, .trap_req, .trap_num, .cpu_int_req, .cpu_int_vec,
      .cpu_int_lvl, .cpu_int_ack, .mem_req, .mem_src, .mem_dst,
      .mem_word, .mem_gnt, .irq);
   irqc_cpu_model irqc_cpu_model_i (.clk, .nrst, .dly, .cpu_int_req,
      .mem_req, .cpu_int_ack, .mem_gnt);

   always #25 clk = ~clk;

   // Record every service the CPU model takes
   always @(posedge clk) begin
      if (cpu_int_req && cpu_int_ack) begin
         lvec <= cpu_int_vec;
         nv   <= nv + 1;
      end
      if (mem_req && mem_gnt) begin
         {lsrc, ldst, lw} <= {mem_src, mem_dst, mem_word};
         nx <= nx + 1;
      end
   end

   task automatic conclude;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // APB cycle; holds the request until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         $display("ERROR %0t: no pready", $time);
         num_errors++;
         conclude();
      end
      {rd, err} = {prdata, pslverr};
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Bounded wait for the service counts to reach their targets
   task automatic svc(input int tv, input int tx);
      int k;
      for (k = 0; k < 60 && !(nv == tv && nx == tx); k++) @(posedge clk) #1;
      if (k == 60) begin
         $display("ERROR %0t: service count %0d %0d", $time, nv, nx);
         num_errors++;
         conclude();
      end
   endtask : svc

   // Two software requests released together by dropping cpu_ilvl
   task automatic pair(input logic [3:0] l6, input logic [3:0] l7,
                       input logic [15:0] v1, input logic [15:0] v2);
      cpu_ilvl <= 4'hF;
      apb(1, 12'h018, {24'h0, 4'hC, l6});
      apb(1, 12'h01C, {24'h0, 4'hC, l7});
      cpu_ilvl <= 4'h0;
      svc(nv + 1, nx);
      chk(lvec, v1);
      svc(nv + 1, nx);
      chk(lvec, v2);
   endtask : pair

   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {fast_in, periph_req, cpu_ilvl, trap_req, trap_num, dly} = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      // Reset values and a refused address
      apb(0, 12'h000, 0);
      chk(rd, 0);
      apb(0, 12'h10C, 0);
      chk(err, 1);
      $display("test reset done");
      // Unassigned node raised by software, request cleared when the vector is acknowledged
      apb(1, 12'h01C, 32'hC5);
      svc(1, 0);
      chk(lvec, 16'h005C);
      apb(0, 12'h01C, 0);
      chk(rd, 32'h45);
      dly <= 4'h3;
      pair(4'h9, 4'h4, 16'h0058, 16'h005C);
      pair(4'hE, 4'hF, 16'h005C, 16'h0058);
      pair(4'h8, 4'h8, 16'h0058, 16'h005C);
      // Equal level must not preempt the running service
      cpu_ilvl <= 4'h9;
      apb(1, 12'h01C, 32'hC9);
      repeat (10) @(posedge clk);
      chk(nv, 7);
      cpu_ilvl <= 4'h8;
      @(posedge clk) #1;
      chk(cpu_int_req, 1);
      svc(8, 0);
      chk(lvec, 16'h005C);
      cpu_ilvl <= 4'h0;
      $display("test priority done");
      // Channel 2: two word moves, then the count-zero vector
      dly <= 4'h0;
      apb(1, 12'h120, 32'h100);
      apb(1, 12'h124, 32'h200);
      apb(1, 12'h128, 32'hE02);
      apb(1, 12'h208, 32'h4);
      apb(1, 12'h008, 32'h53);
      for (i = 0; i < 2; i++) begin
         @(posedge clk) periph_req <= 4'h1;
         @(posedge clk) periph_req <= 4'h0;
         svc(8 + i, i + 1);
         chk({lsrc, ldst, lw}, {24'h100 + 24'(2 * i),
             24'h200 + 24'(2 * i), 1'b1});
      end
      apb(0, 12'h128, 0);
      chk(rd, 32'hE00);
      svc(9, 2);
      chk(lvec, 16'h0048);
      chk(irq, 1);
      apb(0, 12'h204, 0);
      chk(rd, 32'h4);
      @(posedge clk) #1;
      chk(irq, 0);
      $display("test transfer done");
      // Channel 0 continuous, rising, falling and both-edge modes of fast input 0
      apb(1, 12'h100, 32'h300);
      apb(1, 12'h104, 32'h400);
      apb(1, 12'h108, 32'h900);
      apb(1, 12'h000, 32'h51);
      for (i = 1; i < 4; i++) begin
         apb(1, 12'h200, i);
         @(posedge clk) fast_in <= 2'h1;
         repeat (6) @(posedge clk);
         fast_in <= 2'h0;
         repeat (6) @(posedge clk);
         chk(nx, 2 + i + (i == 3));
      end
      chk({lsrc, ldst, lw}, {24'h300, 24'h403, 1'b0});
      apb(0, 12'h108, 0);
      chk(rd, 32'h900);
      $display("test edges done");
      // Software trap enters its own vector
      @(posedge clk) {trap_req, trap_num} <= {1'b1, 8'h2A};
      @(posedge clk) trap_req <= 1'b0;
      svc(10, 6);
      chk(lvec, 16'h00A8);
      $display("test trap done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
